// File: test/cpu_register_set_status_flags_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_register_set_status_flags_tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [4:0] cmd_i = 5'h00;
	logic [7:0] data_i = 8'h00;
	logic [7:0] data2_i = 8'h00;
	logic [2:0] flag_sel_i = 3'h0;
	logic cond_val_i = 1'b0;
	logic shift_carry_i = 1'b0;
	logic [15:0] pc_load_i = 16'h0000;
	logic [15:0] vector_i = 16'h0000;
	logic irq_req_i = 1'b0;
	logic [15:0] sfr_addr_i = 16'h0000;
	logic [7:0] sfr_wdata_i = 8'h00;
	logic sfr_we_i = 1'b0;
	logic [7:0] stack_rdata_i = 8'h00;
	logic [7:0] a_o, x_o, y_o, sp_o, status_o, cpu_mode_o, stack_wdata_o;
	logic [7:0] index_addr_o, mem_result_o;
	logic [15:0] pc_o, stack_addr_o;
	logic stack_we_o, stack_re_o, mem_we_o, branch_taken_o;
	logic irq_ack_o, halted_o, illegal_o, busy_o;
	logic [7:0] ea, ex, ey, esp, est, emode;
	logic [15:0] epc;
	int err_total = 0;
	int total_checks = 0;

	cpu_register_set u_cpu_register_set (
		.clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd_i), .data_i(data_i),
		.data2_i(data2_i), .flag_sel_i(flag_sel_i), .cond_val_i(cond_val_i),
		.shift_carry_i(shift_carry_i), .pc_load_i(pc_load_i),
		.vector_i(vector_i), .irq_req_i(irq_req_i), .sfr_addr_i(sfr_addr_i),
		.sfr_wdata_i(sfr_wdata_i), .sfr_we_i(sfr_we_i),
		.stack_rdata_i(stack_rdata_i), .a_o(a_o), .x_o(x_o), .y_o(y_o),
		.sp_o(sp_o), .pc_o(pc_o), .status_o(status_o),
		.cpu_mode_o(cpu_mode_o), .stack_addr_o(stack_addr_o),
		.stack_wdata_o(stack_wdata_o), .stack_we_o(stack_we_o),
		.stack_re_o(stack_re_o), .index_addr_o(index_addr_o),
		.mem_result_o(mem_result_o), .mem_we_o(mem_we_o),
		.branch_taken_o(branch_taken_o), .irq_ack_o(irq_ack_o),
		.halted_o(halted_o), .illegal_o(illegal_o), .busy_o(busy_o)
	);

	initial begin
		forever #2.5 clk_i = ~clk_i;
	end

	task automatic summarize();
		if (err_total == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : summarize

	task automatic chk(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// returns {overflow, carry, result}; subtract adds ~b so carry = no borrow
	function automatic logic [9:0] addsub(input logic [7:0] a,
		input logic [7:0] b, input logic ci, input logic sub);
		logic [7:0] bb;
		logic [8:0] r;
		bb = sub ? ~b : b;
		r = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
		return {(a[7] == bb[7]) && (r[7] != a[7]), r};
	endfunction : addsub

	function automatic logic [7:0] arith_st(input logic [7:0] s,
		input logic [9:0] r);
		return {r[7], r[9], s[5:2], r[7:0] == 8'h00, r[8]};
	endfunction : arith_st

	function automatic logic [7:0] ld_st(input logic [7:0] s,
		input logic [7:0] v);
		return {v[7], s[6:2], v == 8'h00, s[0]};
	endfunction : ld_st

	function automatic logic [7:0] hi();
		return emode[2] ? 8'h01 : 8'h00;
	endfunction : hi

	task automatic chk_regs();
		chk("a", {8'h00, a_o}, {8'h00, ea});
		chk("x", {8'h00, x_o}, {8'h00, ex});
		chk("y", {8'h00, y_o}, {8'h00, ey});
		chk("sp", {8'h00, sp_o}, {8'h00, esp});
		chk("pc", pc_o, epc);
		chk("status", {8'h00, status_o}, {8'h00, est});
		chk("mode", {8'h00, cpu_mode_o}, {8'h00, emode});
		chk("busy", {15'h0, busy_o}, 16'h0000);
	endtask : chk_regs

	task automatic cmd(input logic [4:0] c, input logic [7:0] d);
		@(posedge clk_i);
		cmd_i <= c;
		data_i <= d;
		@(posedge clk_i);
		cmd_i <= cpu_regs_pkg::CMD_NOP;
		#1;
	endtask : cmd

	task automatic ld(input logic [4:0] c, input logic [7:0] d);
		cmd(c, d);
		est = ld_st(est, d);
		if (c == cpu_regs_pkg::CMD_LD_A) ea = d;
		if (c == cpu_regs_pkg::CMD_LD_X) ex = d;
		if (c == cpu_regs_pkg::CMD_LD_Y) ey = d;
	endtask : ld

	task automatic flg(input logic [4:0] op, input logic [2:0] s);
		flag_sel_i <= s;
		cmd(op, 8'h00);
		if (s != 3'h4) est[s] = (op == cpu_regs_pkg::CMD_SET_FLAG);
		chk_regs();
	endtask : flg

	task automatic sfr(input logic [15:0] ad, input logic [7:0] v);
		@(posedge clk_i);
		sfr_addr_i <= ad;
		sfr_wdata_i <= v;
		sfr_we_i <= 1'b1;
		@(posedge clk_i);
		sfr_we_i <= 1'b0;
		#1;
		if (ad == 16'h003b) emode = v;
		chk("mode", {8'h00, cpu_mode_o}, {8'h00, emode});
	endtask : sfr

	task automatic push(input logic ps);
		logic [7:0] m;
		m = ps ? 8'hef : 8'hff;
		cmd(ps ? cpu_regs_pkg::CMD_PUSH_PS : cpu_regs_pkg::CMD_PUSH_A, 8'h00);
		chk("we", {15'h0, stack_we_o}, 16'h0001);
		chk("addr", stack_addr_o, {hi(), esp});
		chk("wd", {8'h00, stack_wdata_o & m}, {8'h00, (ps ? est : ea) & m});
		esp = esp - 8'h01;
		chk_regs();
	endtask : push

	task automatic pop(input logic ps, input logic [7:0] v);
		cmd(ps ? cpu_regs_pkg::CMD_POP_PS : cpu_regs_pkg::CMD_POP_A, 8'h00);
		esp = esp + 8'h01;
		chk("re", {15'h0, stack_re_o}, 16'h0001);
		chk("busy", {15'h0, busy_o}, 16'h0001);
		chk("addr", stack_addr_o, {hi(), esp});
		@(posedge clk_i);
		stack_rdata_i <= v;
		@(posedge clk_i);
		// read data is only valid one cycle; show a wrong value afterwards
		stack_rdata_i <= ~v;
		#1;
		if (ps) begin
			est = v & 8'hef;
		end else begin
			ea = v;
			est = ld_st(est, v);
		end
		chk_regs();
	endtask : pop

	task automatic intr(input logic software_break_instr);
		logic [15:0] vec;
		vec = 16'($urandom);
		@(posedge clk_i);
		vector_i <= vec;
		cmd_i <= software_break_instr ? cpu_regs_pkg::CMD_BRK : cpu_regs_pkg::CMD_NOP;
		irq_req_i <= ~software_break_instr;
		@(posedge clk_i);
		cmd_i <= cpu_regs_pkg::CMD_NOP;
		irq_req_i <= 1'b0;
		#1;
		chk("ack", {15'h0, irq_ack_o}, 16'h0001);
		for (int k = 0; k < 3; k++) begin
			chk("iwe", {15'h0, stack_we_o}, 16'h0001);
			chk("iaddr", stack_addr_o, {hi(), esp - 8'(k)});
			chk("idata", {8'h00, stack_wdata_o}, {8'h00, k == 0 ? epc[15:8] :
				k == 1 ? epc[7:0] : est | {3'h0, software_break_instr, 4'h0}});
			@(posedge clk_i);
			#1;
		end
		esp = esp - 8'h03;
		epc = vec;
		est[2] = 1'b1;
		chk_regs();
	endtask : intr

	initial begin
		repeat (20000) @(posedge clk_i);
		err_total++;
		summarize();
	end

	initial begin
		logic [7:0] d;
		logic [9:0] r;
		logic [15:0] p;
		logic ack;
		void'($urandom(49));
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		#1;
		{ea, ex, ey, esp, est, emode, epc} = {24'h0, 8'hff, 8'h04, 24'h0};
		chk_regs();
		sfr(16'h003a, 8'hff);
		sfr(16'h003b, 8'h08);
		for (int i = 0; i < 5; i++) begin
			flg(cpu_regs_pkg::CMD_SET_FLAG, i == 4 ? 3'h4 : i == 1 ? 3'h2 :
				i == 2 ? 3'h3 : i == 3 ? 3'h5 : 3'h0);
			flg(cpu_regs_pkg::CMD_CLR_FLAG, flag_sel_i);
		end
		for (int i = 0; i < 4; i++) begin
			ld(cpu_regs_pkg::CMD_LD_X, 8'($urandom));
			ld(cpu_regs_pkg::CMD_LD_Y, 8'($urandom));
			chk_regs();
			d = (i == 0) ? 8'hff : 8'($urandom);
			cmd(cpu_regs_pkg::CMD_INDEX_X, d);
			chk("ix", {8'h00, index_addr_o}, {8'h00, d + ex});
			cmd(cpu_regs_pkg::CMD_INDEX_Y, d);
			chk("iy", {8'h00, index_addr_o}, {8'h00, d + ey});
		end
		ld(cpu_regs_pkg::CMD_LD_A, 8'h80);
		for (int i = 0; i < 24; i++) begin
			d = (i == 0) ? 8'h80 : 8'($urandom);
			r = addsub(ea, d, est[0], i[0]);
			cmd(i[0] ? cpu_regs_pkg::CMD_SBC : cpu_regs_pkg::CMD_ADC, d);
			ea = r[7:0];
			est = arith_st(est, r);
			chk_regs();
		end
		for (int i = 0; i < 4; i++) begin
			d = (i == 0) ? 8'hc0 : 8'($urandom);
			cmd(cpu_regs_pkg::CMD_BIT, d);
			est = {d[7:6], est[5:2], (ea & d) == 8'h00, est[0]};
			chk_regs();
		end
		flg(cpu_regs_pkg::CMD_SET_FLAG, 3'h3);
		for (int i = 0; i < 2; i++) begin
			ld(cpu_regs_pkg::CMD_LD_A, i ? 8'h42 : 8'h58);
			flg(i ? cpu_regs_pkg::CMD_SET_FLAG : cpu_regs_pkg::CMD_CLR_FLAG, 3'h0);
			cmd(i ? cpu_regs_pkg::CMD_SBC : cpu_regs_pkg::CMD_ADC,
				i ? 8'h15 : 8'h46);
			ea = i ? 8'h27 : 8'h04;
			est[0] = 1'b1;
			chk_regs();
		end
		flg(cpu_regs_pkg::CMD_CLR_FLAG, 3'h3);
		ld(cpu_regs_pkg::CMD_LD_A, 8'($urandom));
		d = 8'($urandom) | 8'h01;
		p = {8'h00, ea} * {8'h00, d};
		cmd(cpu_regs_pkg::CMD_MUL, d);
		chk("mul", {y_o, a_o}, p);
		chk("ill", {15'h0, illegal_o}, 16'h0000);
		cmd(cpu_regs_pkg::CMD_DIV, d);
		chk("div", {y_o, a_o}, {8'h00, ea});
		cmd(cpu_regs_pkg::CMD_DIV, 8'h00);
		chk("div0", {y_o, a_o}, {8'h00, ea});
		ey = 8'h00;
		flg(cpu_regs_pkg::CMD_SET_FLAG, 3'h5);
		data2_i <= 8'h3c;
		r = addsub(8'h3c, 8'h4d, est[0], 1'b0);
		cmd(cpu_regs_pkg::CMD_ADC, 8'h4d);
		chk("mem", {8'h00, mem_result_o}, {8'h00, r[7:0]});
		chk("mwe", {15'h0, mem_we_o}, 16'h0001);
		chk("ahold", {8'h00, a_o}, {8'h00, ea});
		est = arith_st(est, r);
		chk_regs();
		for (int i = 0; i < 2; i++) begin
			shift_carry_i <= i[0];
			cmd(cpu_regs_pkg::CMD_SHIFT, 8'h00);
			chk("shc", {15'h0, status_o[0]}, {15'h0, i[0]});
			ea = 8'h00;
			est = {1'b0, est[6:2], 1'b1, i[0]};
			chk_regs();
		end
		// fresh accumulator value before the stack checks
		ld(cpu_regs_pkg::CMD_LD_A, 8'($urandom));
		for (int pg = 0; pg < 2; pg++) begin
			sfr(16'h003b, pg[0] ? 8'h0c : 8'h08);
			cmd(cpu_regs_pkg::CMD_LD_SP, pg[0] ? 8'hff : 8'h7f);
			esp = pg[0] ? 8'hff : 8'h7f;
			pop(1'b1, 8'($urandom) & 8'hc3);
			ld(cpu_regs_pkg::CMD_LD_A, 8'($urandom));
			push(1'b0);
			push(1'b1);
			pop(1'b1, (8'($urandom) & 8'hd3) | 8'h10);
			pop(1'b0, 8'($urandom));
		end
		for (int s = 0; s < 16; s++) begin
			flag_sel_i <= s[2:0];
			cond_val_i <= s[3];
			cmd(cpu_regs_pkg::CMD_BRANCH, 8'h00);
			chk("br", {15'h0, branch_taken_o}, {15'h0, (s[2:0] inside
				{0, 1, 6, 7}) && (est[s[2:0]] == s[3])});
		end
		pc_load_i <= 16'h00ff;
		cmd(cpu_regs_pkg::CMD_PC_LOAD, 8'h00);
		cmd(cpu_regs_pkg::CMD_PC_INC, 8'h00);
		epc = 16'h0100;
		chk_regs();
		intr(1'b0);
		intr(1'b1);
		for (int i = 5'h19; i < 32; i++) begin
			cmd(5'(i), 8'h00);
			chk("ill", {15'h0, illegal_o}, 16'h0001);
		end
		for (int k = 0; k < 2; k++) begin
			cmd(k ? cpu_regs_pkg::CMD_WAIT : cpu_regs_pkg::CMD_STOP, 8'h00);
			chk("halt", {15'h0, halted_o}, 16'h0001);
			irq_req_i <= 1'b1;
			ack = 1'b0;
			for (int n = 0; n < 8 && halted_o !== 1'b0; n++) begin
				@(posedge clk_i);
				#1;
				ack = ack | irq_ack_o;
			end
			irq_req_i <= 1'b0;
			chk("wake", {15'h0, halted_o}, 16'h0000);
			chk("mask", {15'h0, ack}, 16'h0000);
		end
		chk_regs();
		summarize();
	end
endmodule : cpu_register_set_status_flags_tb
`default_nettype wire

// File: verilog/alu_addsub.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpu_regs_map.svh"

module alu_addsub (
	input wire logic [7:0] a_i,
	input wire logic [7:0] b_i,
	input wire logic carry_i,
	input wire logic sub_i,
	input wire logic decimal_i,
	output logic [7:0] sum_o,
	output logic carry_o,
	output logic overflow_o
);

	always_comb begin
		logic [8:0] bin;
		logic [7:0] bb;
		logic [4:0] lo;
		logic [4:0] hi;
		logic lo_c;
		lo = 5'h00;
		hi = 5'h00;
		lo_c = 1'b0;
		bb = sub_i ? ~b_i : b_i;
		bin = {1'b0, a_i} + {1'b0, bb} + {8'h00, carry_i};
		overflow_o = (a_i[7] == bb[7]) && (bin[7] != a_i[7]);
		if (!decimal_i) begin
			sum_o = bin[7:0];
			carry_o = bin[8];
		end else if (!sub_i) begin
			lo = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, carry_i};
			if (lo > `BCD_LIMIT) begin
				lo = lo + `BCD_ADJUST;
			end
			lo_c = lo[4];
			hi = {1'b0, a_i[7:4]} + {1'b0, b_i[7:4]} + {4'h0, lo_c};
			if (hi > `BCD_LIMIT) begin
				hi = hi + `BCD_ADJUST;
			end
			sum_o = {hi[3:0], lo[3:0]};
			carry_o = hi[4];
		end else begin
			// carry in means no borrow, same sense as binary subtract
			lo = {1'b0, a_i[3:0]} - {1'b0, b_i[3:0]} - {4'h0, ~carry_i};
			lo_c = lo[4];
			if (lo_c) begin
				lo = lo - `BCD_ADJUST;
			end
			hi = {1'b0, a_i[7:4]} - {1'b0, b_i[7:4]} - {4'h0, lo_c};
			carry_o = ~hi[4];
			if (hi[4]) begin
				hi = hi - `BCD_ADJUST;
			end
			sum_o = {hi[3:0], lo[3:0]};
		end
	end

endmodule : alu_addsub

`default_nettype wire

// File: verilog/cpu_register_set.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpu_regs_map.svh"

module cpu_register_set (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [4:0] cmd_i,
	input wire logic [7:0] data_i,
	input wire logic [7:0] data2_i,
	input wire logic [2:0] flag_sel_i,
	input wire logic cond_val_i,
	input wire logic shift_carry_i,
	input wire logic [15:0] pc_load_i,
	input wire logic [15:0] vector_i,
	input wire logic irq_req_i,
	input wire logic [15:0] sfr_addr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic sfr_we_i,
	input wire logic [7:0] stack_rdata_i,
	output logic [7:0] a_o,
	output logic [7:0] x_o,
	output logic [7:0] y_o,
	output logic [7:0] sp_o,
	output logic [15:0] pc_o,
	output logic [7:0] status_o,
	output logic [7:0] cpu_mode_o,
	output logic [15:0] stack_addr_o,
	output logic [7:0] stack_wdata_o,
	output logic stack_we_o,
	output logic stack_re_o,
	output logic [7:0] index_addr_o,
	output logic [7:0] mem_result_o,
	output logic mem_we_o,
	output logic branch_taken_o,
	output logic irq_ack_o,
	output logic halted_o,
	output logic illegal_o,
	output logic busy_o
);

	cpu_regs_pkg::state_t state_r, state_nxt;
	cpu_regs_pkg::cmd_t cmd;
	logic [7:0] a_r, x_r, y_r, sp_r, ps_r, mode_r;
	logic [15:0] pc_r;
	logic brk_r, pop_ps_r, idle, int_start, page;
	logic [7:0] alu_sum, alu_lhs;
	logic alu_c, alu_v;
	logic [15:0] product;

	function automatic logic [15:0] stack_addr(input logic pg,
		input logic [7:0] sp);
		stack_addr = {pg ? `STACK_HI_PAGE1 : `STACK_HI_PAGE0, sp}; // RULE_04
	endfunction : stack_addr

	function automatic logic [7:0] nz_flags(input logic [7:0] ps,
		input logic [7:0] v);
		logic [7:0] r;
		r = ps;
		r[`PS_Z] = (v == 8'h00); // RULE_10
		r[`PS_N] = v[7]; // RULE_18
		nz_flags = r;
	endfunction : nz_flags

	assign cmd = cpu_regs_pkg::cmd_t'(cmd_i);
	assign idle = (state_r == cpu_regs_pkg::ST_IDLE);
	assign page = mode_r[`STACK_PAGE_BIT];
	// maskable request only between commands so no command is lost
	assign int_start = idle && ((cmd == cpu_regs_pkg::CMD_BRK) ||
		(cmd == cpu_regs_pkg::CMD_NOP && irq_req_i && !ps_r[`PS_I])); // RULE_11
	assign alu_lhs = ps_r[`PS_T] ? data2_i : a_r; // RULE_14
	assign product = {8'h00, a_r} * {8'h00, data_i};

	alu_addsub u_alu (
		.a_i(alu_lhs),
		.b_i(data_i),
		.carry_i(ps_r[`PS_C]),
		.sub_i(cmd == cpu_regs_pkg::CMD_SBC),
		.decimal_i(ps_r[`PS_D]), // RULE_12
		.sum_o(alu_sum),
		.carry_o(alu_c),
		.overflow_o(alu_v)
	);

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			cpu_regs_pkg::ST_IDLE: begin
				if (int_start) begin
					state_nxt = cpu_regs_pkg::ST_INT_LOW;
				end else if (cmd == cpu_regs_pkg::CMD_POP_A ||
					cmd == cpu_regs_pkg::CMD_POP_PS) begin
					state_nxt = cpu_regs_pkg::ST_POP_WAIT;
				end
			end
			cpu_regs_pkg::ST_INT_LOW: state_nxt = cpu_regs_pkg::ST_INT_STAT;
			cpu_regs_pkg::ST_INT_STAT: state_nxt = cpu_regs_pkg::ST_IDLE;
			cpu_regs_pkg::ST_POP_WAIT: state_nxt = cpu_regs_pkg::ST_POP_LOAD;
			cpu_regs_pkg::ST_POP_LOAD: state_nxt = cpu_regs_pkg::ST_IDLE;
			default: state_nxt = cpu_regs_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= cpu_regs_pkg::ST_IDLE;
			busy_o <= 1'b0;
			brk_r <= 1'b0;
			pop_ps_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			busy_o <= (state_nxt != cpu_regs_pkg::ST_IDLE);
			if (idle) begin
				brk_r <= (cmd == cpu_regs_pkg::CMD_BRK);
				pop_ps_r <= (cmd == cpu_regs_pkg::CMD_POP_PS);
			end
		end
	end

	// accumulator and index registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			a_r <= `A_RESET;
			x_r <= `A_RESET;
			y_r <= `A_RESET;
		end else if (state_r == cpu_regs_pkg::ST_POP_LOAD && !pop_ps_r) begin
			a_r <= stack_rdata_i; // RULE_06
		end else if (idle) begin
			unique case (cmd)
				cpu_regs_pkg::CMD_LD_A, cpu_regs_pkg::CMD_SHIFT:
					a_r <= data_i; // RULE_01
				cpu_regs_pkg::CMD_LD_X: x_r <= data_i;
				cpu_regs_pkg::CMD_LD_Y: y_r <= data_i;
				cpu_regs_pkg::CMD_ADC, cpu_regs_pkg::CMD_SBC: begin
					if (!ps_r[`PS_T]) begin
						a_r <= alu_sum;
					end
				end
				cpu_regs_pkg::CMD_MUL: begin
					a_r <= product[7:0]; // RULE_15
					y_r <= product[15:8];
				end
				cpu_regs_pkg::CMD_DIV: begin
					// divide by zero leaves both registers untouched
					if (data_i != 8'h00) begin
						a_r <= 8'(({y_r, a_r} / {8'h00, data_i})); // RULE_15
						y_r <= 8'(({y_r, a_r} % {8'h00, data_i}));
					end
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sp_r <= `SP_RESET;
		end else if (int_start || state_r == cpu_regs_pkg::ST_INT_LOW ||
			state_r == cpu_regs_pkg::ST_INT_STAT) begin
			sp_r <= sp_r - 8'h01; // RULE_20
		end else if (idle) begin
			unique case (cmd)
				cpu_regs_pkg::CMD_LD_SP: sp_r <= data_i;
				cpu_regs_pkg::CMD_PUSH_A, cpu_regs_pkg::CMD_PUSH_PS:
					sp_r <= sp_r - 8'h01; // RULE_06
				cpu_regs_pkg::CMD_POP_A, cpu_regs_pkg::CMD_POP_PS:
					sp_r <= sp_r + 8'h01; // RULE_21
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pc_r <= `PC_RESET;
		end else if (state_r == cpu_regs_pkg::ST_INT_STAT) begin
			pc_r <= vector_i;
		end else if (idle && !int_start) begin
			if (cmd == cpu_regs_pkg::CMD_PC_LOAD) begin
				pc_r <= pc_load_i; // RULE_05
			end else if (cmd == cpu_regs_pkg::CMD_PC_INC) begin
				pc_r <= pc_r + 16'h0001; // RULE_05
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ps_r <= `PS_RESET;
		end else if (state_r == cpu_regs_pkg::ST_INT_STAT) begin
			ps_r[`PS_I] <= 1'b1;
		end else if (state_r == cpu_regs_pkg::ST_POP_LOAD && pop_ps_r) begin
			ps_r <= stack_rdata_i;
			ps_r[`PS_B] <= 1'b0; // RULE_13
		end else if (state_r == cpu_regs_pkg::ST_POP_LOAD) begin
			ps_r <= nz_flags(ps_r, stack_rdata_i); // RULE_10
		end else if (idle && !int_start) begin
			unique case (cmd)
				cpu_regs_pkg::CMD_LD_A, cpu_regs_pkg::CMD_LD_X,
				cpu_regs_pkg::CMD_LD_Y:
					ps_r <= nz_flags(ps_r, data_i); // RULE_10
				cpu_regs_pkg::CMD_SHIFT: begin
					ps_r <= nz_flags(ps_r, data_i);
					ps_r[`PS_C] <= shift_carry_i; // RULE_09
				end
				cpu_regs_pkg::CMD_ADC, cpu_regs_pkg::CMD_SBC: begin
					ps_r[`PS_C] <= alu_c; // RULE_09
					// z v n are meaningless in decimal, so they hold
					if (!ps_r[`PS_D]) begin // RULE_08
						ps_r[`PS_Z] <= (alu_sum == 8'h00);
						ps_r[`PS_N] <= alu_sum[7];
						ps_r[`PS_V] <= alu_v; // RULE_17
					end
				end
				cpu_regs_pkg::CMD_BIT: begin
					ps_r[`PS_Z] <= ((a_r & data_i) == 8'h00);
					ps_r[`PS_V] <= data_i[6]; // RULE_17
					ps_r[`PS_N] <= data_i[7]; // RULE_18
				end
				cpu_regs_pkg::CMD_SET_FLAG, cpu_regs_pkg::CMD_CLR_FLAG: begin
					if (flag_sel_i != 3'(`PS_B)) begin // RULE_13
						ps_r[flag_sel_i] <= (cmd == cpu_regs_pkg::CMD_SET_FLAG);
					end
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_r <= `CPU_MODE_RESET;
		end else if (sfr_we_i && sfr_addr_i == `CPU_MODE_ADDR) begin
			mode_r <= sfr_wdata_i; // RULE_19
		end
	end

	// stack port; read data is expected one cycle after the strobe
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stack_addr_o <= `PC_RESET;
			stack_wdata_o <= `A_RESET;
			stack_we_o <= 1'b0;
			stack_re_o <= 1'b0;
		end else begin
			stack_we_o <= 1'b0;
			stack_re_o <= 1'b0;
			if (int_start) begin
				stack_addr_o <= stack_addr(page, sp_r);
				stack_wdata_o <= pc_r[15:8]; // RULE_20
				stack_we_o <= 1'b1;
			end else if (state_r == cpu_regs_pkg::ST_INT_LOW) begin
				stack_addr_o <= stack_addr(page, sp_r);
				stack_wdata_o <= pc_r[7:0]; // RULE_20
				stack_we_o <= 1'b1;
			end else if (state_r == cpu_regs_pkg::ST_INT_STAT) begin
				stack_addr_o <= stack_addr(page, sp_r);
				stack_wdata_o <= ps_r | ({7'h00, brk_r} << `PS_B); // RULE_13
				stack_we_o <= 1'b1;
			end else if (idle) begin
				unique case (cmd)
					cpu_regs_pkg::CMD_PUSH_A, cpu_regs_pkg::CMD_PUSH_PS: begin
						stack_addr_o <= stack_addr(page, sp_r);
						stack_wdata_o <= (cmd == cpu_regs_pkg::CMD_PUSH_A) ?
							a_r : ps_r; // RULE_06
						stack_we_o <= 1'b1;
					end
					cpu_regs_pkg::CMD_POP_A, cpu_regs_pkg::CMD_POP_PS: begin
						stack_addr_o <= stack_addr(page, sp_r + 8'h01); // RULE_21
						stack_re_o <= 1'b1;
					end
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			index_addr_o <= `A_RESET;
			mem_result_o <= `A_RESET;
			mem_we_o <= 1'b0;
			branch_taken_o <= 1'b0;
			irq_ack_o <= 1'b0;
			halted_o <= 1'b0;
			illegal_o <= 1'b0;
		end else begin
			mem_we_o <= 1'b0;
			branch_taken_o <= 1'b0;
			illegal_o <= 1'b0;
			irq_ack_o <= int_start;
			if (irq_req_i) begin
				halted_o <= 1'b0;
			end
			if (idle && !int_start) begin
				unique case (cmd)
					cpu_regs_pkg::CMD_INDEX_X:
						index_addr_o <= data_i + x_r; // RULE_02
					cpu_regs_pkg::CMD_INDEX_Y:
						index_addr_o <= data_i + y_r; // RULE_03
					cpu_regs_pkg::CMD_ADC, cpu_regs_pkg::CMD_SBC: begin
						mem_result_o <= alu_sum;
						mem_we_o <= ps_r[`PS_T]; // RULE_14
					end
					cpu_regs_pkg::CMD_BRANCH: begin
						// only C Z V N may be tested
						branch_taken_o <= (flag_sel_i == 3'(`PS_C) ||
							flag_sel_i == 3'(`PS_Z) ||
							flag_sel_i == 3'(`PS_V) ||
							flag_sel_i == 3'(`PS_N)) &&
							(ps_r[flag_sel_i] == cond_val_i); // RULE_07
					end
					cpu_regs_pkg::CMD_STOP, cpu_regs_pkg::CMD_WAIT:
						halted_o <= 1'b1; // RULE_15
					cpu_regs_pkg::CMD_NOP, cpu_regs_pkg::CMD_LD_A,
					cpu_regs_pkg::CMD_LD_X, cpu_regs_pkg::CMD_LD_Y,
					cpu_regs_pkg::CMD_LD_SP, cpu_regs_pkg::CMD_SHIFT,
					cpu_regs_pkg::CMD_BIT, cpu_regs_pkg::CMD_SET_FLAG,
					cpu_regs_pkg::CMD_CLR_FLAG, cpu_regs_pkg::CMD_PUSH_A,
					cpu_regs_pkg::CMD_PUSH_PS, cpu_regs_pkg::CMD_POP_A,
					cpu_regs_pkg::CMD_POP_PS, cpu_regs_pkg::CMD_BRK,
					cpu_regs_pkg::CMD_PC_LOAD, cpu_regs_pkg::CMD_PC_INC,
					cpu_regs_pkg::CMD_MUL, cpu_regs_pkg::CMD_DIV: ;
					// fast-set and slow-wait have no code and land here
					default: illegal_o <= 1'b1; // RULE_15
				endcase
			end
		end
	end

	assign a_o = a_r;
	assign x_o = x_r;
	assign y_o = y_r;
	assign sp_o = sp_r;
	assign pc_o = pc_r;
	assign status_o = ps_r;
	assign cpu_mode_o = mode_r;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_push_page: assert property (idle && cmd == cpu_regs_pkg::CMD_PUSH_A
		|=> stack_we_o && stack_addr_o == stack_addr($past(page), // RULE_04
		$past(sp_o)) && sp_o == $past(sp_o) - 8'h01)
		else $error("push address or pointer wrong");
	a_pop_order: assert property (idle && !int_start && // RULE_21
		cmd == cpu_regs_pkg::CMD_POP_A
		|=> (stack_re_o && stack_addr_o[7:0] == sp_o) ##2
		(a_o == $past(stack_rdata_i)))
		else $error("pop order wrong");
	a_int_order: assert property (idle && cmd == cpu_regs_pkg::CMD_BRK // RULE_20
		|=> (stack_we_o && stack_wdata_o == pc_o[15:8]) ##1
		(stack_wdata_o == pc_o[7:0]) ##1
		(stack_we_o && stack_wdata_o[`PS_B]) ##1 status_o[`PS_I])
		else $error("interrupt push sequence wrong");
	a_break_zero: assert property (status_o[`PS_B] == 1'b0) // RULE_13
		else $error("break bit set in register");
	a_irq_mask: assert property (idle && status_o[`PS_I] && // RULE_11
		cmd != cpu_regs_pkg::CMD_BRK |=> !irq_ack_o)
		else $error("masked interrupt taken");
	a_zero_flag: assert property (idle && !int_start && // RULE_10
		cmd == cpu_regs_pkg::CMD_LD_A
		|=> status_o[`PS_Z] == (a_o == 8'h00) && status_o[`PS_N] == a_o[7])
		else $error("zero or negative flag wrong");
	a_shift_carry: assert property (idle && !int_start && // RULE_09
		cmd == cpu_regs_pkg::CMD_SHIFT |=> status_o[`PS_C] ==
		$past(shift_carry_i)) else $error("shift carry lost");
	a_bit_copy: assert property (idle && !int_start && // RULE_17
		cmd == cpu_regs_pkg::CMD_BIT |=> status_o[7:6] == $past(data_i[7:6]))
		else $error("bit-test copy wrong");
	a_decimal_hold: assert property (idle && !int_start && // RULE_08
		status_o[`PS_D] && cmd == cpu_regs_pkg::CMD_ADC
		|=> $stable(status_o[`PS_N]) && $stable(status_o[`PS_Z]) &&
		$stable(status_o[`PS_V])) else $error("decimal flags changed");
	a_pc_step: assert property (idle && !int_start && // RULE_05
		cmd == cpu_regs_pkg::CMD_PC_INC |=> pc_o == $past(pc_o) + 16'h0001)
		else $error("program counter step wrong");
	a_index_sum: assert property (idle && !int_start && // RULE_02
		cmd == cpu_regs_pkg::CMD_INDEX_X
		|=> index_addr_o == $past(data_i) + $past(x_o))
		else $error("indexed address wrong");

	c_brk: cover property (idle && cmd == cpu_regs_pkg::CMD_BRK);
	c_irq: cover property (irq_ack_o && !brk_r);
	c_pop_ps: cover property (state_r == cpu_regs_pkg::ST_POP_LOAD && pop_ps_r);
	c_dec_adc: cover property (idle && status_o[`PS_D] &&
		cmd == cpu_regs_pkg::CMD_ADC);

endmodule : cpu_register_set

`default_nettype wire

// File: verilog/cpu_regs_map.svh
// How it works
// (RULE_01) 8-bit accumulator carries most data operations
// (RULE_02) first index register adds to operand
// (RULE_03) second index register adds to operand
// (RULE_04) stack high byte follows page bit
// (RULE_05) 16-bit program counter holds next address
// (RULE_06) push and pop accumulator and status
// (RULE_07) eight status bits; branches test C Z V N
// (RULE_08) decimal mode leaves Z V N invalid
// (RULE_09) bit 0 takes carry, shift, rotate
// (RULE_10) bit 1 set on zero result
// (RULE_11) bit 2 blocks all but break
// (RULE_12) bit 3 selects binary or decimal add/subtract
// (RULE_13) bit 4 reads 0; break push sets it
// (RULE_14) bit 5 enables memory-to-memory operations
// (RULE_15) no fast-set/slow-wait; stop, wait, multiply, divide
// (RULE_16) software keeps mode register bit 3 set
// (RULE_17) bit 6 signed overflow; bit-test copies bit 6
// (RULE_18) bit 7 negative; bit-test copies bit 7
// (RULE_19) page bit lives in mode register 003b
// (RULE_20) interrupt pushes PC high, low, status
// (RULE_21) pop increments pointer, then reads stack
`ifndef CPU_REGS_MAP_SVH
`define CPU_REGS_MAP_SVH

`define PS_C 0
`define PS_Z 1
`define PS_I 2
`define PS_D 3
`define PS_B 4
`define PS_T 5
`define PS_V 6
`define PS_N 7

`define PS_RESET 8'h04
`define SP_RESET 8'hff
`define PC_RESET 16'h0000
`define A_RESET 8'h00
`define CPU_MODE_RESET 8'h00
`define CPU_MODE_ADDR 16'h003b
`define STACK_PAGE_BIT 2
`define STACK_HI_PAGE0 8'h00
`define STACK_HI_PAGE1 8'h01
`define BCD_LIMIT 5'h09
`define BCD_ADJUST 5'h06

`endif

// File: verilog/cpu_regs_pkg.sv
package cpu_regs_pkg;

	typedef enum logic [4:0] {
		CMD_NOP = 5'h00,
		CMD_LD_A = 5'h01,
		CMD_LD_X = 5'h02,
		CMD_LD_Y = 5'h03,
		CMD_LD_SP = 5'h04,
		CMD_ADC = 5'h05,
		CMD_SBC = 5'h06,
		CMD_SHIFT = 5'h07,
		CMD_BIT = 5'h08,
		CMD_SET_FLAG = 5'h09,
		CMD_CLR_FLAG = 5'h0a,
		CMD_PUSH_A = 5'h0b,
		CMD_PUSH_PS = 5'h0c,
		CMD_POP_A = 5'h0d,
		CMD_POP_PS = 5'h0e,
		CMD_BRK = 5'h0f,
		CMD_PC_LOAD = 5'h10,
		CMD_PC_INC = 5'h11,
		CMD_INDEX_X = 5'h12,
		CMD_INDEX_Y = 5'h13,
		CMD_BRANCH = 5'h14,
		CMD_STOP = 5'h15,
		CMD_WAIT = 5'h16,
		CMD_MUL = 5'h17,
		CMD_DIV = 5'h18
	} cmd_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_INT_LOW = 3'h1,
		ST_INT_STAT = 3'h3,
		ST_POP_WAIT = 3'h4,
		ST_POP_LOAD = 3'h5
	} state_t;

endpackage : cpu_regs_pkg
